// [verif/host_model.sv]
// Host side of the register port: single byte writes and reads.
// Assumes the bank samples requests on the rising edge of i_clock.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic       i_clock,
	input  wire logic [7:0] i_read_data,
	output logic            o_write,
	output logic            o_read,
	output logic      [7:0] o_address,
	output logic      [7:0] o_write_data,
	output logic            o_unlock_ok
);
	initial
	begin
		o_write = 1'b0;
		o_read = 1'b0;
		o_address = 8'h00;
		o_write_data = 8'h00;
		o_unlock_ok = 1'b0;
	end

	// Released bus shows inverted data, never the last value
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input logic u);
		@(posedge i_clock);
		#1;
		o_write = 1'b1;
		o_address = a;
		o_write_data = d;
		o_unlock_ok = u;
		@(posedge i_clock);
		#1;
		o_write = 1'b0;
		o_unlock_ok = 1'b0;
		o_address = ~a;
		o_write_data = ~d;
	endtask

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clock);
		#1;
		o_read = 1'b1;
		o_address = a;
		@(posedge i_clock);
		#1;
		o_read = 1'b0;
		o_address = ~a;
		d = i_read_data;
	endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench of the regulator set-point register bank.
// Assumes the design package is compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int W = ldo_setpoint_pkg::MV_WIDTH;
	logic         clock, reset_n, wr, rd, unl, trk, asreg;
	logic [7:0]   adr, wdat, buck3, rdat, code, d;
	logic [W-1:0] mv1, mv2, mv3;
	int           fails, total_checks;
	int           t1 [16] = '{1000, 1100, 1200, 1250, 1300, 1350, 1400, 1500,
		1600, 1800, 2500, 2750, 2800, 3000, 3100, 3300};

	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	host_model host (.i_clock(clock), .i_read_data(rdat), .o_write(wr), .o_read(rd),
		.o_address(adr), .o_write_data(wdat), .o_unlock_ok(unl));
	ldo_setpoint_registers uut (.i_clock(clock), .i_reset_n(reset_n), .i_write(wr),
		.i_read(rd), .i_address(adr), .i_write_data(wdat), .i_unlock_ok(unl),
		.i_buck3_setpoint_reg(buck3), .o_read_data(rdat), .o_reg1_mv(mv1),
		.o_reg2_mv(mv2), .o_reg2_tracking(trk), .o_reg2_target_code(code),
		.o_reg3_mv(mv3), .o_reg3_as_regulator(asreg));

	function automatic int mv2_of(input int c);
		if (c < 25) return 900 + 25 * c;
		if (c < 32) return 1550 + 50 * (c - 25);
		if (c < 48) return 1900 + 50 * (c - 32);
		if (c < 53) return 2700 + 50 * (c - 48);
		if (c < 56) return 3000 + 100 * (c - 53);
		return 3300;
	endfunction

	function automatic int mv3_of(input int c);
		if (c < 9) return 1500 + 50 * c;
		if (c < 14) return 2000 + 100 * (c - 9);
		return 2450 + 50 * (c - 14);
	endfunction

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_mv(input logic [W-1:0] got, input int exp);
		total_checks++;
		if (got !== exp[W-1:0])
		begin
			fails++;
			$display("[FAIL] %0t mV got %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic settle();
		@(posedge clock);
		#1;
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		#200000;
		fails++;
		finish_test();
	end

	initial
	begin
		fails = 0;
		total_checks = 0;
		reset_n = 1'b0;
		buck3 = 8'hA5;
		repeat (4) @(posedge clock);
		#1;
		reset_n = 1'b1;
		settle();
		check_mv(mv1, 1800);
		check_mv(mv2, 3300);
		check_mv(mv3, 1800);
		check8({6'h00, trk, asreg}, 8'h00);
		check8(code, 8'h38);
		host.read_reg(8'h12, d);
		check8(d, 8'h09);
		host.read_reg(8'h13, d);
		check8(d, 8'h38);
		host.read_reg(8'h14, d);
		check8(d, 8'h06);
		host.read_reg(8'h11, d);
		check8(d, 8'h00);
		host.write_reg(8'h12, 8'hFF, 1'b0);
		host.read_reg(8'h12, d);
		check8(d, 8'h09);
		host.write_reg(8'h14, 8'hFF, 1'b0);
		host.read_reg(8'h14, d);
		check8(d, 8'h06);
		$display("reset and lock test done");
		for (int c = 0; c < 16; c++)
		begin
			host.write_reg(8'h12, {4'hA, c[3:0]}, 1'b1);
			settle();
			check_mv(mv1, t1[c]);
			host.read_reg(8'h12, d);
			check8(d, {4'hA, c[3:0]});
		end
		for (int c = 0; c < 64; c++)
		begin
			host.write_reg(8'h13, {2'b10, c[5:0]}, 1'b1);
			settle();
			check_mv(mv2, mv2_of(c));
			check8(code, {2'b00, c[5:0]});
			host.read_reg(8'h13, d);
			check8(d, {2'b10, c[5:0]});
		end
		for (int c = 0; c < 32; c++)
		begin
			host.write_reg(8'h14, {3'b111, c[4:0]}, 1'b1);
			settle();
			check_mv(mv3, mv3_of(c));
			check8({7'h00, asreg}, 8'h01);
			host.read_reg(8'h14, d);
			check8(d, {3'b111, c[4:0]});
		end
		$display("decode test done");
		host.write_reg(8'h13, 8'h7F, 1'b1);
		settle();
		check8({7'h00, trk}, 8'h01);
		check8(code, 8'hA5);
		buck3 = 8'h3C;
		settle();
		check8(code, 8'h3C);
		$display("tracking test done");
		reset_n = 1'b0;
		repeat (2) settle();
		check8(code, 8'h00);
		reset_n = 1'b1;
		settle();
		check8({7'h00, trk}, 8'h00);
		check8(code, 8'h38);
		check_mv(mv2, 3300);
		check_mv(mv3, 1800);
		host.read_reg(8'h13, d);
		check8(d, 8'h38);
		host.read_reg(8'h14, d);
		check8(d, 8'h06);
		$display("mid-run reset test done");
		finish_test();
	end
endmodule
`default_nettype wire

// [verilog/ldo_setpoint_pkg.sv]
// Constants of the regulator set-point register bank.
// Assumes byte-wide registers reached by an 8-bit register address.
package ldo_setpoint_pkg;
	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] LINEAR_REG_1_SETPOINT_OFFSET = 8'h12;
	localparam logic [7:0] LINEAR_REG_2_SETPOINT_OFFSET = 8'h13;
	localparam logic [7:0] SWITCH1_LINEAR_REG_3_OFFSET  = 8'h14;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] LINEAR_REG_1_SETPOINT_RESET = 8'h09;
	localparam logic [7:0] LINEAR_REG_2_SETPOINT_RESET = 8'h38;
	localparam logic [7:0] SWITCH1_LINEAR_REG_3_RESET  = 8'h06;
	localparam logic [7:0] READ_UNMAPPED       = 8'h00;

	// ****************************************************************
	// Field layout
	// ****************************************************************
	localparam int REG1_VSEL_WIDTH    = 4;
	localparam int REG2_VSEL_WIDTH    = 6;
	localparam int REG3_VSEL_WIDTH    = 5;
	localparam int TRACK_BIT          = 6;
	localparam int SWITCH_OR_REG_BIT  = 5;
	localparam int MV_WIDTH           = 12;
	localparam int REG2_TOP_CODE      = 56;
	localparam int REG2_TOP_MV        = 3300;
endpackage

// [verilog/ldo_setpoint_registers.sv]
// Set-point registers of three linear regulators with decoded targets.
// Assumes an upstream serial slave presents byte accesses synchronous to
// i_clock and reports in i_unlock_ok that the password unlock just completed.
`timescale 1ns/1ps
`default_nettype none
module ldo_setpoint_registers #(
	parameter int         MV_WIDTH  = ldo_setpoint_pkg::MV_WIDTH,
	parameter logic [7:0] LS1_RESET = ldo_setpoint_pkg::SWITCH1_LINEAR_REG_3_RESET
) (
	input  wire logic                i_clock,
	input  wire logic                i_reset_n,
	input  wire logic                i_write,
	input  wire logic                i_read,
	input  wire logic [7:0]          i_address,
	input  wire logic [7:0]          i_write_data,
	input  wire logic                i_unlock_ok,
	input  wire logic [7:0]          i_buck3_setpoint_reg,
	output logic      [7:0]          o_read_data,
	output logic      [MV_WIDTH-1:0] o_reg1_mv,
	output logic      [MV_WIDTH-1:0] o_reg2_mv,
	output logic                     o_reg2_tracking,
	output logic      [7:0]          o_reg2_target_code,
	output logic      [MV_WIDTH-1:0] o_reg3_mv,
	output logic                     o_reg3_as_regulator
);
	// Elaboration-time guard: the decode tables need 12 bits for 3300 mV
	if (MV_WIDTH < 12)
	begin : mv_width_check
		$error("MV_WIDTH too small for 3300 mV");
	end

	// ****************************************************************
	// Decode tables
	// ****************************************************************
	function automatic logic [MV_WIDTH-1:0] reg1_mv(input logic [3:0] code);
		logic [11:0] v;
		case (code)
			4'h0: v = 12'd1000;
			4'h1: v = 12'd1100;
			4'h2: v = 12'd1200;
			4'h3: v = 12'd1250;
			4'h4: v = 12'd1300;
			4'h5: v = 12'd1350;
			4'h6: v = 12'd1400;
			4'h7: v = 12'd1500;
			4'h8: v = 12'd1600;
			4'h9: v = 12'd1800;
			4'hA: v = 12'd2500;
			4'hB: v = 12'd2750;
			4'hC: v = 12'd2800;
			4'hD: v = 12'd3000;
			4'hE: v = 12'd3100;
			default: v = 12'd3300;
		endcase
		return MV_WIDTH'(v);
	endfunction

	function automatic logic [MV_WIDTH-1:0] reg2_mv(input logic [5:0] code);
		int c;
		int v;
		c = int'(code);
		if (c < 16)
			v = 900 + 25 * c;
		else if (c < 25)
			v = 1300 + 25 * (c - 16);
		else if (c < 32)
			v = 1550 + 50 * (c - 25);
		else if (c < 48)
			v = 1900 + 50 * (c - 32);
		else if (c < 53)
			v = 2700 + 50 * (c - 48);
		else if (c < ldo_setpoint_pkg::REG2_TOP_CODE)
			v = 3000 + 100 * (c - 53);
		else
			v = ldo_setpoint_pkg::REG2_TOP_MV;
		return MV_WIDTH'(v);
	endfunction

	function automatic logic [MV_WIDTH-1:0] reg3_mv(input logic [4:0] code);
		int c;
		int v;
		c = int'(code);
		if (c < 9)
			v = 1500 + 50 * c;
		else if (c < 14)
			v = 2000 + 100 * (c - 9);
		else
			v = 2450 + 50 * (c - 14);
		return MV_WIDTH'(v);
	endfunction

	// ****************************************************************
	// Register file
	// ****************************************************************
	logic [7:0] linear_reg_1_setpoint_q;
	logic [7:0] linear_reg_1_setpoint_d;
	logic [7:0] linear_reg_2_setpoint_q;
	logic [7:0] linear_reg_2_setpoint_d;
	logic [7:0] switch1_linear_reg_3_control_q;
	logic [7:0] switch1_linear_reg_3_control_d;
	logic [7:0] read_data_d;
	logic       write_ok;

	always_comb
	begin
		write_ok               = i_write && i_unlock_ok;
		linear_reg_1_setpoint_d        = linear_reg_1_setpoint_q;
		linear_reg_2_setpoint_d        = linear_reg_2_setpoint_q;
		switch1_linear_reg_3_control_d = switch1_linear_reg_3_control_q;
		if (write_ok && i_address == ldo_setpoint_pkg::LINEAR_REG_1_SETPOINT_OFFSET)
			linear_reg_1_setpoint_d = i_write_data;
		if (write_ok && i_address == ldo_setpoint_pkg::LINEAR_REG_2_SETPOINT_OFFSET)
			linear_reg_2_setpoint_d = i_write_data;
		if (write_ok && i_address == ldo_setpoint_pkg::SWITCH1_LINEAR_REG_3_OFFSET)
			switch1_linear_reg_3_control_d = i_write_data;
		case (i_address)
			ldo_setpoint_pkg::LINEAR_REG_1_SETPOINT_OFFSET: read_data_d = linear_reg_1_setpoint_q;
			ldo_setpoint_pkg::LINEAR_REG_2_SETPOINT_OFFSET: read_data_d = linear_reg_2_setpoint_q;
			ldo_setpoint_pkg::SWITCH1_LINEAR_REG_3_OFFSET:  read_data_d = switch1_linear_reg_3_control_q;
			default:                                read_data_d = ldo_setpoint_pkg::READ_UNMAPPED;
		endcase
		if (!i_read)
			read_data_d = o_read_data;
	end

	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			linear_reg_1_setpoint_q        <= ldo_setpoint_pkg::LINEAR_REG_1_SETPOINT_RESET;
			linear_reg_2_setpoint_q        <= ldo_setpoint_pkg::LINEAR_REG_2_SETPOINT_RESET;
			switch1_linear_reg_3_control_q <= LS1_RESET;
			o_read_data            <= ldo_setpoint_pkg::READ_UNMAPPED;
		end
		else
		begin
			linear_reg_1_setpoint_q        <= linear_reg_1_setpoint_d;
			linear_reg_2_setpoint_q        <= linear_reg_2_setpoint_d;
			switch1_linear_reg_3_control_q <= switch1_linear_reg_3_control_d;
			o_read_data            <= read_data_d;
		end
	end

	// ****************************************************************
	// Decoded regulator targets
	// ****************************************************************
	logic [MV_WIDTH-1:0] reg1_mv_d;
	logic [MV_WIDTH-1:0] reg2_mv_d;
	logic [MV_WIDTH-1:0] reg3_mv_d;
	logic [7:0]          reg2_target_d;

	always_comb
	begin
		reg1_mv_d = reg1_mv(linear_reg_1_setpoint_q[ldo_setpoint_pkg::REG1_VSEL_WIDTH-1:0]);
		reg2_mv_d = reg2_mv(linear_reg_2_setpoint_q[ldo_setpoint_pkg::REG2_VSEL_WIDTH-1:0]);
		reg3_mv_d = reg3_mv(switch1_linear_reg_3_control_q[ldo_setpoint_pkg::REG3_VSEL_WIDTH-1:0]);
		if (linear_reg_2_setpoint_q[ldo_setpoint_pkg::TRACK_BIT])
			reg2_target_d = i_buck3_setpoint_reg;
		else
			reg2_target_d = {2'h0, linear_reg_2_setpoint_q[ldo_setpoint_pkg::REG2_VSEL_WIDTH-1:0]};
	end

	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_reg1_mv           <= '0;
			o_reg2_mv           <= '0;
			o_reg2_tracking     <= 1'b0;
			o_reg2_target_code  <= 8'h00;
			o_reg3_mv           <= '0;
			o_reg3_as_regulator <= 1'b0;
		end
		else
		begin
			o_reg1_mv           <= reg1_mv_d;
			o_reg2_mv           <= reg2_mv_d;
			o_reg2_tracking     <= linear_reg_2_setpoint_q[ldo_setpoint_pkg::TRACK_BIT];
			o_reg2_target_code  <= reg2_target_d;
			o_reg3_mv           <= reg3_mv_d;
			o_reg3_as_regulator <= switch1_linear_reg_3_control_q[ldo_setpoint_pkg::SWITCH_OR_REG_BIT];
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	locked_write_held_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		i_write && !i_unlock_ok |=> $stable(linear_reg_1_setpoint_q) && $stable(linear_reg_2_setpoint_q)
			&& $stable(switch1_linear_reg_3_control_q))
		else $error("locked write changed a register");
	linear_reg_1_write_stores_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		i_write && i_unlock_ok && i_address == ldo_setpoint_pkg::LINEAR_REG_1_SETPOINT_OFFSET
			|=> linear_reg_1_setpoint_q == $past(i_write_data))
		else $error("unlocked write to 0x12 not stored");
	linear_reg_2_write_stores_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		i_write && i_unlock_ok && i_address == ldo_setpoint_pkg::LINEAR_REG_2_SETPOINT_OFFSET
			|=> linear_reg_2_setpoint_q == $past(i_write_data))
		else $error("unlocked write to 0x13 not stored");
	ls1_write_stores_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		i_write && i_unlock_ok && i_address == ldo_setpoint_pkg::SWITCH1_LINEAR_REG_3_OFFSET
			|=> switch1_linear_reg_3_control_q == $past(i_write_data))
		else $error("unlocked write to 0x14 not stored");
	ls1_readback_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		i_read && i_address == ldo_setpoint_pkg::SWITCH1_LINEAR_REG_3_OFFSET
			|=> o_read_data == $past(switch1_linear_reg_3_control_q))
		else $error("read of 0x14 wrong");
	reg1_decode_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		linear_reg_1_setpoint_q[3:0] == 4'h9 |=> o_reg1_mv == MV_WIDTH'(1800))
		else $error("regulator 1 code 1001 not 1800 mV");
	reg2_top_codes_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		linear_reg_2_setpoint_q[5:0] >= 6'h38 |=> o_reg2_mv == MV_WIDTH'(3300))
		else $error("regulator 2 top code not 3300 mV");
	reg2_tracking_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		linear_reg_2_setpoint_q[6] |=> o_reg2_target_code == $past(i_buck3_setpoint_reg) && o_reg2_tracking)
		else $error("tracking target not buck 3 set-point");
	reg2_own_code_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		!linear_reg_2_setpoint_q[6] |=> o_reg2_target_code == {2'h0, $past(linear_reg_2_setpoint_q[5:0])})
		else $error("own regulator 2 code not used");
	reg3_mode_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		##1 o_reg3_as_regulator == $past(switch1_linear_reg_3_control_q[5]))
		else $error("regulator 3 mode bit not followed");
	reg3_decode_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		switch1_linear_reg_3_control_q[4:0] == 5'h1F |=> o_reg3_mv == MV_WIDTH'(3300))
		else $error("regulator 3 top code not 3300 mV");
	unmapped_read_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		i_read && i_address != ldo_setpoint_pkg::LINEAR_REG_1_SETPOINT_OFFSET
			&& i_address != ldo_setpoint_pkg::LINEAR_REG_2_SETPOINT_OFFSET
			&& i_address != ldo_setpoint_pkg::SWITCH1_LINEAR_REG_3_OFFSET
			|=> o_read_data == ldo_setpoint_pkg::READ_UNMAPPED)
		else $error("unmapped read not zero");
endmodule
`default_nettype wire
